// File: rce_pkg.sv
// constants, types and pin groups for the reset entry and clock output block
// assumes a single 40 MHz input clock shared by every module of the block
package rce_pkg;

  // input clock period, for reference when turning times into counts
  localparam int unsigned CLOCK_PERIOD_NS = 25;

  // output clock is the input clock divided by two
  localparam int unsigned CLKOUT_DIV = 2;

  // output clock periods from reset release to first bus activity
  localparam int unsigned STARTUP_CLKOUT = 7;
  localparam int unsigned STARTUP_CYCLES = STARTUP_CLKOUT * CLKOUT_DIV;
  localparam logic [4:0] STARTUP_LAST = 5'(STARTUP_CYCLES - 1);

  // least reset low time the outside source keeps, in output clock periods
  localparam int unsigned MIN_RESET_CLKOUT = 4;

  // input clock periods the output clock is held low on resync
  localparam int unsigned RESYNC_LOW_CYCLES = 2;
  localparam logic [1:0] RESYNC_HOLD_INIT = 2'(RESYNC_LOW_CYCLES - 1);

  // output clock level after reset
  localparam logic CLKOUT_RESET = 1'b0;

  // serial mode 0 shift clock phases, in processor clocks
  localparam logic [7:0] SER_LOW_LONG  = 8'h02;
  localparam logic [7:0] SER_LOW_SHORT = 8'h01;
  localparam logic [7:0] SER_HIGH_ONE  = 8'h01;
  localparam int unsigned SER_BITS     = 8;
  localparam logic [2:0] SER_LAST_BIT  = 3'(SER_BITS - 1);
  localparam logic [7:0] SER_DIV_ONE   = 8'h01;

  // bus pins that turn into pulled-up inputs during reset
  typedef struct packed {
    logic       lock;
    logic       top_address_emul_select;
    logic [2:0] upper_address_lines;
  } bus_pins_s;

  // serial mode 0 engine states, gray along idle-low-high-end
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_LOW  = 2'b01,
    SER_HIGH = 2'b11,
    SER_END  = 2'b10
  } ser_state_e;

endpackage

// File: ser_mode0.sv
// synchronous serial mode 0 engine: shift clock on txd, data on rxd
// assumes rxd arrives from a pin and is resynchronised here
`timescale 1ns/100ps
module ser_mode0 (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       abort,
  input  wire logic       start,
  input  wire logic       rx_mode,
  input  wire logic [7:0] divisor,
  input  wire logic [7:0] tx_byte,
  input  wire logic       rxd_i,
  output logic            rxd_o,
  output logic            rxd_oe,
  output logic            txd_o,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_byte
);

  rce_pkg::ser_state_e state_r;
  logic [7:0]          cnt_r;
  logic [2:0]          bit_r;
  logic [7:0]          sh_r;
  logic                sck_r;
  logic                oe_r;
  logic                dout_r;
  logic                rx_r;
  logic                one_r;
  logic [7:0]          high_len_r;
  logic                done_r;
  logic                rxd_s1;
  logic                rxd_s2;
  logic [7:0]          div_seen_r;
  logic [7:0]          high_run_r;

  wire       div_one  = (divisor <= rce_pkg::SER_DIV_ONE);
  wire [7:0] low_init = one_r ? rce_pkg::SER_LOW_SHORT - 8'h01
                              : rce_pkg::SER_LOW_LONG - 8'h01;
  wire       cnt_zero = (cnt_r == 8'h00);
  wire       last_bit = (bit_r == rce_pkg::SER_LAST_BIT);
  // n-1 high clocks, or one when n is 0 or 1
  wire [7:0] high_want = (div_seen_r <= rce_pkg::SER_DIV_ONE) ? rce_pkg::SER_HIGH_ONE
                                                              : div_seen_r - 8'h01;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd_i;
      rxd_s2 <= rxd_s1;
    end
  end

  // checker helper: divisor taken at start and high samples so far
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_seen_r <= 8'h00;
      high_run_r <= 8'h00;
    end else begin
      high_run_r <= sck_r ? high_run_r + 8'h01 : 8'h00;
      if (start && state_r == rce_pkg::SER_IDLE) begin
        div_seen_r <= divisor;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r    <= rce_pkg::SER_IDLE;
      cnt_r      <= 8'h00;
      bit_r      <= 3'h0;
      sh_r       <= 8'h00;
      sck_r      <= 1'b1;
      oe_r       <= 1'b0;
      dout_r     <= 1'b1;
      rx_r       <= 1'b0;
      one_r      <= 1'b0;
      high_len_r <= 8'h00;
      done_r     <= 1'b0;
    end else if (abort) begin
      // reset entry drops any transfer and releases the data pin
      state_r <= rce_pkg::SER_IDLE;
      sck_r   <= 1'b1;
      oe_r    <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        rce_pkg::SER_IDLE: if (start) begin
          state_r    <= rce_pkg::SER_LOW;
          sh_r       <= tx_byte;
          dout_r     <= tx_byte[0];
          rx_r       <= rx_mode;
          one_r      <= div_one;
          high_len_r <= div_one ? rce_pkg::SER_HIGH_ONE - 8'h01 : divisor - 8'h02;
          cnt_r      <= div_one ? rce_pkg::SER_LOW_SHORT - 8'h01
                                : rce_pkg::SER_LOW_LONG - 8'h01;
          bit_r      <= 3'h0;
          sck_r      <= 1'b0;
          oe_r       <= !rx_mode;
        end
        rce_pkg::SER_LOW: if (!cnt_zero) begin
          cnt_r <= cnt_r - 8'h01;
        end else begin
          sck_r <= 1'b1;
          if (rx_r) begin
            sh_r <= {rxd_s2, sh_r[7:1]};
          end
          state_r <= last_bit ? rce_pkg::SER_END : rce_pkg::SER_HIGH;
          cnt_r   <= high_len_r;
        end
        rce_pkg::SER_HIGH: if (!cnt_zero) begin
          cnt_r <= cnt_r - 8'h01;
        end else begin
          state_r <= rce_pkg::SER_LOW;
          sck_r   <= 1'b0;
          cnt_r   <= low_init;
          bit_r   <= bit_r + 3'h1;
          if (!rx_r) begin
            sh_r   <= {1'b0, sh_r[7:1]};
            dout_r <= sh_r[1];
          end
        end
        rce_pkg::SER_END: begin
          oe_r    <= 1'b0;
          done_r  <= 1'b1;
          state_r <= rce_pkg::SER_IDLE;
        end
        default: state_r <= rce_pkg::SER_IDLE;
      endcase
    end
  end

  assign txd_o   = sck_r;
  assign rxd_o   = dout_r;
  assign rxd_oe  = oe_r;
  assign busy    = (state_r != rce_pkg::SER_IDLE);
  assign done    = done_r;
  assign rx_byte = sh_r;

  a_low_long: assert property (@(posedge clock) disable iff (!rstn || abort)
    $fell(sck_r) && !one_r |-> !sck_r ##1 !sck_r ##1 sck_r)
    else $error("shift clock low phase not two clocks");

  a_low_short: assert property (@(posedge clock) disable iff (!rstn || abort)
    $fell(sck_r) && one_r |-> !sck_r ##1 sck_r)
    else $error("shift clock low phase not one clock");

  a_high_len: assert property (@(posedge clock) disable iff (!rstn || abort)
    $fell(sck_r) && bit_r != 3'h0 |-> (high_run_r == high_want))
    else $error("shift clock high phase length wrong");

  a_rx_sample: assert property (@(posedge clock) disable iff (!rstn || abort)
    $rose(sck_r) && rx_r |-> sh_r[7] == $past(rxd_s2))
    else $error("receive bit not taken at rising shift clock");

  a_tx_stable: assert property (@(posedge clock) disable iff (!rstn || abort)
    $rose(sck_r) && oe_r |-> $stable(dout_r))
    else $error("transmit data moved at rising shift clock");

  a_float_end: assert property (@(posedge clock) disable iff (!rstn || abort)
    state_r == rce_pkg::SER_END |=> !oe_r && done_r)
    else $error("data pin not released after last rise");

  a_abort_serial: assert property (@(posedge clock) disable iff (!rstn)
    abort |=> sck_r && !oe_r && !done_r)
    else $error("serial transfer not dropped on reset");

endmodule

// File: reset_and_clock_entry.sv
// reset entry, output clock divider and start-up delay of the processor
// assumes reset_in_n and the top address bus pin come from outside and are resynchronised
`timescale 1ns/100ps
module reset_and_clock_entry (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               reset_in_n,
  input  wire logic               bus_busy,
  input  wire rce_pkg::bus_pins_s core_bus_o,
  input  wire rce_pkg::bus_pins_s core_bus_oe,
  input  wire rce_pkg::bus_pins_s bus_pin_i,
  output rce_pkg::bus_pins_s      bus_pin_o,
  output rce_pkg::bus_pins_s      bus_pin_oe,
  output logic                    clkout,
  output logic                    in_reset,
  output logic                    bus_abort,
  output logic                    bus_start,
  output logic                    bus_enable,
  output logic                    emul_float,
  input  wire logic               ser_start,
  input  wire logic               ser_rx_mode,
  input  wire logic [7:0]         ser_divisor,
  input  wire logic [7:0]         ser_tx_byte,
  input  wire logic               rxd_i,
  output logic                    rxd_o,
  output logic                    rxd_oe,
  output logic                    txd_o,
  output logic                    ser_busy,
  output logic                    ser_done,
  output logic [7:0]              ser_rx_byte
);

  logic       rin_s1;
  logic       rin_s2;
  logic       rin_d_r;
  logic       top_s1;
  logic       top_s2;
  logic       clk_out_r;
  logic [1:0] hold_cnt_r;
  logic       waiting_r;
  logic [4:0] wait_cnt_r;
  logic       bus_enable_r;
  logic       emul_float_r;

  // reset pin and emulation select pin, two flops each
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rin_s1 <= 1'b0;
      rin_s2 <= 1'b0;
      top_s1 <= 1'b1;
      top_s2 <= 1'b1;
    end else begin
      rin_s1 <= reset_in_n;
      rin_s2 <= rin_s1;
      top_s1 <= bus_pin_i.top_address_emul_select;
      top_s2 <= top_s1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rin_d_r <= 1'b0;
    end else begin
      rin_d_r <= rin_s2;
    end
  end

  wire reset_act   = !rin_s2;
  wire release_evt = rin_s2 && !rin_d_r;
  wire assert_evt  = !rin_s2 && rin_d_r;
  wire hold_active = (hold_cnt_r != 2'h0);
  wire start_now   = waiting_r && (wait_cnt_r == rce_pkg::STARTUP_LAST);

  // divide by two; resync low on release while high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clk_out_r  <= rce_pkg::CLKOUT_RESET;
      hold_cnt_r <= 2'h0;
    end else if (release_evt && clk_out_r) begin
      clk_out_r  <= 1'b0;
      hold_cnt_r <= rce_pkg::RESYNC_HOLD_INIT;
    end else if (hold_active) begin
      hold_cnt_r <= hold_cnt_r - 2'h1;
    end else begin
      clk_out_r <= !clk_out_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waiting_r    <= 1'b0;
      wait_cnt_r   <= 5'h00;
      bus_enable_r <= 1'b0;
    end else if (reset_act) begin
      waiting_r    <= 1'b0;
      wait_cnt_r   <= 5'h00;
      bus_enable_r <= 1'b0;
    end else if (release_evt) begin
      waiting_r  <= 1'b1;
      wait_cnt_r <= 5'h00;
    end else if (start_now) begin
      waiting_r    <= 1'b0;
      bus_enable_r <= 1'b1;
    end else if (waiting_r) begin
      wait_cnt_r <= wait_cnt_r + 5'h01;
    end
  end

  // only the top address pin decides float mode; caught while reset holds
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      emul_float_r <= 1'b0;
    end else if (reset_act) begin
      emul_float_r <= !top_s2;
    end
  end

  // drop the cycle under way the moment reset is seen
  assign bus_abort = assert_evt && bus_busy;

  // pins turn to inputs while reset holds or in float mode
  wire pins_off = reset_act || emul_float_r;
  assign bus_pin_o  = core_bus_o;
  assign bus_pin_oe = pins_off ? '0 : core_bus_oe;

  assign clkout     = clk_out_r;
  assign in_reset   = reset_act;
  assign bus_start  = start_now;
  assign bus_enable = bus_enable_r;
  assign emul_float = emul_float_r;

  // serial engine stops in reset and waits for bus start-up
  wire ser_go = ser_start && bus_enable_r;

  ser_mode0 u_ser (
    .clock   (clock),
    .rstn    (rstn),
    .abort   (reset_act),
    .start   (ser_go),
    .rx_mode (ser_rx_mode),
    .divisor (ser_divisor),
    .tx_byte (ser_tx_byte),
    .rxd_i   (rxd_i),
    .rxd_o   (rxd_o),
    .rxd_oe  (rxd_oe),
    .txd_o   (txd_o),
    .busy    (ser_busy),
    .done    (ser_done),
    .rx_byte (ser_rx_byte)
  );

  sequence release_high;
    release_evt && clk_out_r;
  endsequence

  sequence held_low_two;
    !clk_out_r ##1 !clk_out_r ##1 clk_out_r;
  endsequence

  a_resync_low: assert property (@(posedge clock) disable iff (!rstn || reset_act)
    release_high |=> held_low_two)
    else $error("output clock not held low two clocks on resync");

  a_resync_none: assert property (@(posedge clock) disable iff (!rstn)
    release_evt && !clk_out_r |=> clk_out_r)
    else $error("output clock disturbed on release while low");

  a_clk_divide: assert property (@(posedge clock) disable iff (!rstn)
    !release_evt && !hold_active |=> clk_out_r != $past(clk_out_r))
    else $error("output clock failed to toggle");

  a_start_delay: assert property (@(posedge clock) disable iff (!rstn)
    bus_start |-> $past(release_evt, 14))
    else $error("bus start not seven output clocks after release");

  a_no_early: assert property (@(posedge clock) disable iff (!rstn)
    release_evt |=> !bus_enable_r [*8])
    else $error("bus enabled too soon after release");

  a_reset_hold: assert property (@(posedge clock) disable iff (!rstn)
    reset_act |=> !bus_enable_r && !bus_start)
    else $error("bus active during reset");

  a_abort_now: assert property (@(posedge clock) disable iff (!rstn)
    $fell(rin_s2) && bus_busy |-> bus_abort ##1 !bus_enable_r)
    else $error("bus cycle not abandoned on reset");

  a_pins_float: assert property (@(posedge clock) disable iff (!rstn)
    reset_act |-> bus_pin_oe == '0)
    else $error("bus pins driven during reset");

  a_float_mode: assert property (@(posedge clock) disable iff (!rstn)
    $rose(rin_s2) |-> emul_float_r == !$past(top_s2))
    else $error("float mode not taken from top address pin");

  a_emul_pins_off: assert property (@(posedge clock) disable iff (!rstn)
    emul_float_r |-> bus_pin_oe == '0)
    else $error("bus pins driven in emulation float mode");

  a_abort_once: assert property (@(posedge clock) disable iff (!rstn)
    bus_abort |=> !bus_abort)
    else $error("bus abort longer than one clock");

endmodule

// File: reset_fixture.sv
// outside reset source and emulation fixture for the reset entry block
// assumes the bench calls its tasks at falling clock edges
`timescale 1ns/100ps
module reset_fixture (
  input  wire logic               clock,
  input  wire rce_pkg::bus_pins_s pin_o,
  input  wire rce_pkg::bus_pins_s pin_oe,
  output logic                    reset_pin_n,
  output rce_pkg::bus_pins_s      pin_level
);
  localparam int MIN_HOLD = rce_pkg::MIN_RESET_CLKOUT * rce_pkg::CLKOUT_DIV;
  logic pull_top_low;
  int   low_cnt;
  initial begin
    reset_pin_n = 1'b0;
    pull_top_low = 1'b0;
    low_cnt = 0;
  end
  always @(posedge clock) begin
    low_cnt <= reset_pin_n ? 0 : low_cnt + 1;
  end
  // only the top line pulled low, others ride their pull-ups
  assign pin_level = (pin_o & pin_oe) | (~pin_oe & ~(pull_top_low ? 5'h08 : 5'h00));
  task automatic assert_reset(input logic emul);
    reset_pin_n = 1'b0;
    pull_top_low = emul;
  endtask
  // never released before the least low time
  task automatic release_reset();
    while (low_cnt < MIN_HOLD) @(negedge clock);
    reset_pin_n = 1'b1;
  endtask
endmodule

// File: reset_and_clock_entry_tb_top.sv
// self-checking bench for reset entry, output clock and serial mode 0
// assumes the fixture model drives the reset pin and the pulled-up bus pins
`timescale 1ns/100ps
module reset_and_clock_entry_tb_top;
  typedef struct packed {
    logic       rx;
    logic [7:0] div;
    logic [7:0] data;
    logic [7:0] lo;
    logic [7:0] hi;
  } ser_row_s;
  localparam ser_row_s ROWS [5] = '{'{1'b0, 8'h01, 8'hA5, 8'h01, 8'h01},
    '{1'b0, 8'h03, 8'h3C, 8'h02, 8'h02}, '{1'b0, 8'h08, 8'h81, 8'h02, 8'h07},
    '{1'b1, 8'h04, 8'h96, 8'h02, 8'h03}, '{1'b1, 8'h02, 8'h5A, 8'h02, 8'h01}};
  logic               clock, rstn, reset_in_n, bus_busy, clkout, in_reset;
  logic               bus_abort, bus_start, bus_enable, emul_float;
  logic               ser_start, ser_rx_mode, rxd_i, rxd_o, rxd_oe, txd_o;
  logic               ser_busy, ser_done, rx_drive;
  logic [7:0]         ser_divisor, ser_tx_byte, ser_rx_byte;
  rce_pkg::bus_pins_s core_bus_o, core_bus_oe, bus_pin_i, bus_pin_o, bus_pin_oe;
  int                 n_errors, comparisons;
  // data wire resolved from the device enable
  assign rxd_i = rxd_oe ? rxd_o : rx_drive;
  reset_and_clock_entry i_dut (.clock(clock), .rstn(rstn), .reset_in_n(reset_in_n),
    .bus_busy(bus_busy), .core_bus_o(core_bus_o), .core_bus_oe(core_bus_oe),
    .bus_pin_i(bus_pin_i), .bus_pin_o(bus_pin_o), .bus_pin_oe(bus_pin_oe), .clkout(clkout),
    .in_reset(in_reset), .bus_abort(bus_abort), .bus_start(bus_start),
    .bus_enable(bus_enable), .emul_float(emul_float), .ser_start(ser_start),
    .ser_rx_mode(ser_rx_mode), .ser_divisor(ser_divisor), .ser_tx_byte(ser_tx_byte),
    .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o), .ser_busy(ser_busy),
    .ser_done(ser_done), .ser_rx_byte(ser_rx_byte));
  reset_fixture i_fix (.clock(clock), .pin_o(bus_pin_o), .pin_oe(bus_pin_oe),
    .reset_pin_n(reset_in_n), .pin_level(bus_pin_i));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic release_check(input logic want);
    int   t0, starts, at, run, runmax;
    logic prev, was_high;
    while (clkout !== want) @(negedge clock);
    i_fix.release_reset();
    t0 = 0;
    while (in_reset !== 1'b0 && t0 < 10) begin
      @(negedge clock);
      t0++;
    end
    check(16'(t0), 16'h0002);
    starts = 0;
    at = 0;
    run = 0;
    runmax = 0;
    prev = clkout;
    was_high = clkout;
    for (int i = 1; i <= 20; i++) begin
      @(negedge clock);
      if (bus_start === 1'b1) begin
        starts++;
        at = i;
      end
      run = (clkout === prev) ? run + 1 : 0;
      runmax = (run > runmax) ? run : runmax;
      prev = clkout;
    end
    check(16'(runmax), 16'(was_high));
    check(16'(was_high), 16'(want));
    check(16'(at), 16'(rce_pkg::STARTUP_CYCLES));
    check(16'(starts), 16'h0001);
    check(16'(bus_enable), 16'h0001);
    $display("test reset release done");
  endtask
  task automatic run_row(input ser_row_s r);
    int         k, lo, hi, n_lo, n_hi;
    logic [7:0] got;
    logic       fin;
    ser_start = 1'b1;
    ser_rx_mode = r.rx;
    ser_divisor = r.div;
    ser_tx_byte = r.rx ? ~r.data : r.data;
    rx_drive = r.data[0];
    @(negedge clock);
    ser_start = 1'b0;
    {k, lo, hi, n_lo, n_hi, got, fin} = '0;
    for (int c = 0; c < 400 && !fin; c++) begin
      if (txd_o === 1'b0) begin
        if (hi != 0 && k > 0) n_hi += (hi == r.hi);
        hi = 0;
        lo++;
      end else begin
        if (lo != 0) begin
          n_lo += (lo == r.lo);
          if (k < 8) got[k] = rxd_o;
          k++;
          if (k < 8) rx_drive = r.data[k];
        end
        lo = 0;
        hi++;
      end
      fin = (ser_done === 1'b1);
      @(negedge clock);
    end
    check(16'(k), 16'h0008);
    check(16'(n_lo), 16'h0008);
    check(16'(n_hi), 16'h0007);
    check(r.rx ? 16'(ser_rx_byte) : 16'(got), 16'(r.data));
    check(16'({rxd_oe, ser_busy}), 16'h0000);
    $display("test serial row done");
  endtask
  task automatic warm(input logic emul);
    int aborts, held;
    bus_busy = 1'b1;
    i_fix.assert_reset(emul);
    aborts = 0;
    held = 0;
    repeat (12) begin
      @(negedge clock);
      aborts += (bus_abort === 1'b1);
      held += (in_reset === 1'b1 && bus_pin_oe === 5'h00);
    end
    bus_busy = 1'b0;
    check(16'(aborts), 16'h0001);
    check(16'(held), 16'h000B);
    release_check(emul);
    check(16'(bus_pin_o), 16'(core_bus_o));
    check(16'(emul_float), 16'(emul));
    check(16'(bus_pin_oe), emul ? 16'h0000 : 16'h001F);
    $display("test warm reset done");
  endtask
  task automatic cut_serial();
    int dones, aborts;
    ser_start = 1'b1;
    ser_rx_mode = 1'b0;
    ser_divisor = 8'h08;
    ser_tx_byte = 8'hC3;
    @(negedge clock);
    ser_start = 1'b0;
    repeat (6) @(negedge clock);
    check(16'({rxd_oe, ser_busy}), 16'h0003);
    ser_start = 1'b1;
    i_fix.assert_reset(1'b0);
    {dones, aborts} = '0;
    repeat (12) begin
      @(negedge clock);
      dones += (ser_done === 1'b1);
      aborts += (bus_abort === 1'b1);
    end
    ser_start = 1'b0;
    check(16'({txd_o, rxd_oe, ser_busy}), 16'h0004);
    check(16'(dones + aborts), 16'h0000);
    release_check(1'b1);
    $display("test serial cut done");
  endtask
  initial begin
    #(25 * 20000);
    n_errors++;
    close_out();
  end
  initial begin
    {n_errors, comparisons} = '0;
    {rstn, bus_busy, ser_start, ser_rx_mode, rx_drive} = '0;
    core_bus_o = 5'h15;
    core_bus_oe = 5'h1F;
    ser_divisor = 8'h01;
    ser_tx_byte = 8'h00;
    repeat (5) @(negedge clock);
    check(16'({clkout, in_reset, bus_enable, txd_o, rxd_oe, emul_float}), 16'h0014);
    check(16'(bus_pin_oe), 16'h0000);
    rstn = 1'b1;
    repeat (10) @(negedge clock);
    release_check(1'b0);
    foreach (ROWS[i]) run_row(ROWS[i]);
    cut_serial();
    run_row(ROWS[3]);
    warm(1'b1);
    warm(1'b0);
    close_out();
  end
endmodule
